// ==== hw/servo_port_pkg.sv ====
// Purpose: shared constants for the servo axis control port
// Assumes: 250 MHz system clock
// Notes:   offsets are five-bit I/O addresses, board-relative except 0x12
package servo_port_pkg;
    // =========================================================
    // register offsets
    localparam logic [4:0] OFF_PORT_A      = 5'h00;
    localparam logic [4:0] OFF_PORT_B      = 5'h01;
    localparam logic [4:0] OFF_PORT_C      = 5'h02;
    localparam logic [4:0] OFF_PORT_CTRL   = 5'h03;
    localparam logic [4:0] OFF_DAC1_LO     = 5'h08;
    localparam logic [4:0] OFF_DAC1_HI     = 5'h09;
    localparam logic [4:0] OFF_DAC2_LO     = 5'h0a;
    localparam logic [4:0] OFF_DAC2_HI     = 5'h0b;
    localparam logic [4:0] OFF_LATCH_BOARD = 5'h10;
    localparam logic [4:0] OFF_LATCH_ALL   = 5'h12;

    // =========================================================
    // field positions
    localparam int A_MODE_LSB   = 0;
    localparam int A_MODE_W     = 3;
    localparam int A_LED1       = 3;
    localparam int A_LED2       = 4;
    localparam int A_SYN_A      = 5;
    localparam int A_SYN_B      = 6;
    localparam int A_SYN_I      = 7;
    localparam int B_ENC_REAL   = 0;
    localparam int B_DAC_JOINT  = 1;
    localparam int B_SCLK_EN    = 2;
    localparam int B_DBL_BUF    = 3;
    localparam int B_IDX_EN     = 4;
    localparam int C_HB1        = 0;
    localparam int C_IDX1       = 1;
    localparam int C_HB2        = 2;
    localparam int C_IDX2       = 3;
    localparam int C_ADC_IDLE   = 4;

    // =========================================================
    // reset values and widths
    localparam logic [7:0] PORT_A_RST    = 8'h00;
    localparam logic [7:0] PORT_B_RST    = 8'h00;
    localparam logic [7:0] PORT_CTRL_RST = 8'h00;
    localparam logic [7:0] RDATA_UNMAP   = 8'h00;
    localparam int         DAC_W         = 12;
    localparam int         AXES          = 2;

    // =========================================================
    // timing
    localparam longint CLK_KHZ      = 250000;
    localparam longint HB_TIME_MS   = 50;
    localparam longint HB_CYCLES    = HB_TIME_MS * CLK_KHZ;
    localparam int     HB_CNT_W     = 24;
endpackage : servo_port_pkg

// ==== hw/dac_cmd_if.sv ====
// Purpose: carries converter load commands to one channel
// Assumes: all signals on sys_clk
// Notes:   strobes are one-cycle pulses
`timescale 1ns/1ps
interface dac_cmd_if;
    logic       wr_lo;
    logic       wr_hi;
    logic [7:0] wdata;
    logic       latch;
    logic       dbl_buf;
    modport ctrl (output wr_lo, output wr_hi, output wdata, output latch, output dbl_buf);
    modport chan (input wr_lo, input wr_hi, input wdata, input latch, input dbl_buf);
endinterface : dac_cmd_if

// ==== hw/dac_channel.sv ====
// Purpose: two-stage setpoint latch of one converter channel
// Assumes: low byte is written before the high nibble
// Notes:   output comes from a register
`timescale 1ns/1ps
module dac_channel #(
    parameter int W = 12
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // commands
    dac_cmd_if.chan           cmd,
    // converter output
    output logic [W-1:0]      dac_out
);
    logic [7:0]   lo_reg;
    logic [W-1:0] first_reg;
    logic [W-1:0] out_reg;
    logic [W-1:0] word_next;

    assign word_next = {cmd.wdata[W-9:0], lo_reg};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lo_reg    <= 8'h00;
            first_reg <= '0;
            out_reg   <= '0;
        end else begin
            if (cmd.wr_lo) begin
                lo_reg <= cmd.wdata;
            end
            if (cmd.wr_hi) begin
                first_reg <= word_next;
            end
            if (!cmd.dbl_buf && cmd.wr_hi) begin
                out_reg <= word_next;
            end else if (cmd.dbl_buf && cmd.latch) begin
                // one sample of delay: setpoint lands on the next latch
                out_reg <= first_reg;
            end
        end
    end

    assign dac_out = out_reg;
endmodule : dac_channel

// ==== hw/servo_axis_control_port.sv ====
// Purpose: control and status ports of a two-axis servo board
// Assumes: host bus strobes already on sys_clk, one cycle each
// Notes:   converter and counter devices sit outside this block
`timescale 1ns/1ps

// Behaviour
// - normal mode output follows written value
// - double-buffered output updates on board latch
// - one sample period setpoint delay
// - port A 0-2 drives shared counter mode
// - port A 5-7 synthetic encoder A,B,I
// - port B 0 selects synthetic or real
// - port B 1 selects loopback or joints
// - sample strobe counts only with B2
// - B3 selects high-write or latch update
// - B4 low clears index flags, high arms
// - armed index pulse latches counter value
// - port C 0 joint 1 heartbeat
// - low byte write retriggers heartbeat
// - port C 1 joint 1 index seen
// - port C 2,3 same for joint 2
// - port C 4 high when converters idle
// - access 0x10 or 0x12 makes latch
// - heartbeat is 50 ms retriggerable one-shot
module servo_axis_control_port
    import servo_port_pkg::*;
#(
    parameter longint HB_TICKS        = servo_port_pkg::HB_CYCLES,
    parameter bit     DAC_ON_SW_LATCH = 1'b1
) (
    // clock and reset
    input  wire logic                               sys_clk,
    input  wire logic                               nrst,
    // host i/o bus
    input  wire logic                               board_hit,
    input  wire logic [4:0]                         io_addr,
    input  wire logic                               io_wr,
    input  wire logic                               io_rd,
    input  wire logic [7:0]                         io_wdata,
    output logic      [7:0]                         io_rdata,
    // backplane and board pins
    input  wire logic                               sample_strobe_line,
    input  wire logic                               adc_busy,
    input  wire logic [servo_port_pkg::AXES-1:0]    joint_enc_a,
    input  wire logic [servo_port_pkg::AXES-1:0]    joint_enc_b,
    input  wire logic [servo_port_pkg::AXES-1:0]    joint_enc_i,
    // to the encoder counter units
    output logic [servo_port_pkg::A_MODE_W-1:0]     counter_mode,
    output logic [servo_port_pkg::AXES-1:0]         counter_enc_a,
    output logic [servo_port_pkg::AXES-1:0]         counter_enc_b,
    output logic [servo_port_pkg::AXES-1:0]         counter_enc_i,
    output logic [servo_port_pkg::AXES-1:0]         counter_capture,
    // analog section and indicators
    output logic                                    board_latch,
    output logic                                    dac_to_joints,
    output logic [servo_port_pkg::DAC_W-1:0]        dac1_out,
    output logic [servo_port_pkg::DAC_W-1:0]        dac2_out,
    output logic [servo_port_pkg::AXES-1:0]         diag_led,
    output logic [servo_port_pkg::AXES-1:0]         heartbeat
);
    import servo_port_pkg::*;

    // =========================================================
    // reset release
    logic rst_s1_reg;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    // =========================================================
    // pin synchronisers
    localparam int SYNC_W = 2 + 3 * AXES;
    logic [SYNC_W-1:0] pin_s1_reg;
    logic [SYNC_W-1:0] pin_s2_reg;
    logic              strobe_d_reg;
    logic              strobe_s;
    logic              busy_s;
    logic [AXES-1:0]   enc_a_s;
    logic [AXES-1:0]   enc_b_s;
    logic [AXES-1:0]   enc_i_s;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg   <= '0;
            pin_s2_reg   <= '0;
            strobe_d_reg <= 1'b0;
        end else begin
            pin_s1_reg   <= {sample_strobe_line, adc_busy, joint_enc_a, joint_enc_b,
                             joint_enc_i};
            pin_s2_reg   <= pin_s1_reg;
            strobe_d_reg <= strobe_s;
        end
    end

    assign strobe_s = pin_s2_reg[SYNC_W-1];
    assign busy_s   = pin_s2_reg[SYNC_W-2];
    assign enc_a_s  = pin_s2_reg[3*AXES-1:2*AXES];
    assign enc_b_s  = pin_s2_reg[2*AXES-1:AXES];
    assign enc_i_s  = pin_s2_reg[AXES-1:0];

    // =========================================================
    // address decode
    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        hit = (a == off);
    endfunction : hit

    logic board_wr;
    logic board_rd;
    logic wr_a;
    logic wr_b;
    logic wr_ctrl;
    logic wr_d1_lo;
    logic wr_d1_hi;
    logic wr_d2_lo;
    logic wr_d2_hi;
    logic sw_latch;

    assign board_wr = board_hit && io_wr;
    assign board_rd = board_hit && io_rd;
    // port C is never written: it has no write decode at all
    assign wr_a     = board_wr && hit(io_addr, OFF_PORT_A);
    assign wr_b     = board_wr && hit(io_addr, OFF_PORT_B);
    assign wr_ctrl  = board_wr && hit(io_addr, OFF_PORT_CTRL);
    assign wr_d1_lo = board_wr && hit(io_addr, OFF_DAC1_LO);
    assign wr_d1_hi = board_wr && hit(io_addr, OFF_DAC1_HI);
    assign wr_d2_lo = board_wr && hit(io_addr, OFF_DAC2_LO);
    assign wr_d2_hi = board_wr && hit(io_addr, OFF_DAC2_HI);
    // 0x12 latches every board, so it ignores the board select
    assign sw_latch = ((board_hit && hit(io_addr, OFF_LATCH_BOARD))
                      || hit(io_addr, OFF_LATCH_ALL)) && (io_wr || io_rd);

    // =========================================================
    // output ports
    logic [7:0] port_a_reg;
    logic [7:0] port_b_reg;
    logic [7:0] port_ctrl_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_a_reg    <= PORT_A_RST;
            port_b_reg    <= PORT_B_RST;
            port_ctrl_reg <= PORT_CTRL_RST;
        end else begin
            if (wr_a)    port_a_reg    <= io_wdata;
            if (wr_b)    port_b_reg    <= io_wdata;
            if (wr_ctrl) port_ctrl_reg <= io_wdata;
        end
    end

    logic sclk_en;
    logic dbl_buf;
    logic idx_en;

    assign sclk_en = port_b_reg[B_SCLK_EN];
    assign dbl_buf = port_b_reg[B_DBL_BUF];
    assign idx_en  = port_b_reg[B_IDX_EN];

    // =========================================================
    // board latch
    logic strobe_rise;
    logic latch_next;
    logic dac_latch;
    logic latch_reg;
    logic dac_latch_reg;

    assign strobe_rise = strobe_s && !strobe_d_reg && sclk_en;
    assign latch_next  = strobe_rise || sw_latch;
    // software latch reaches the converters only when strapped to
    assign dac_latch   = strobe_rise || (sw_latch && DAC_ON_SW_LATCH);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg     <= 1'b0;
            dac_latch_reg <= 1'b0;
        end else begin
            latch_reg     <= latch_next;
            dac_latch_reg <= dac_latch;
        end
    end

    // =========================================================
    // converter channels
    dac_cmd_if d1_cmd ();
    dac_cmd_if d2_cmd ();

    assign d1_cmd.wr_lo   = wr_d1_lo;
    assign d1_cmd.wr_hi   = wr_d1_hi;
    assign d1_cmd.wdata   = io_wdata;
    assign d1_cmd.latch   = dac_latch_reg;
    assign d1_cmd.dbl_buf = dbl_buf;
    assign d2_cmd.wr_lo   = wr_d2_lo;
    assign d2_cmd.wr_hi   = wr_d2_hi;
    assign d2_cmd.wdata   = io_wdata;
    assign d2_cmd.latch   = dac_latch_reg;
    assign d2_cmd.dbl_buf = dbl_buf;

    dac_channel #(.W(DAC_W)) u_dac1 (
        .clk     (sys_clk),
        .rst_n   (rst_n),
        .cmd     (d1_cmd),
        .dac_out (dac1_out)
    );

    dac_channel #(.W(DAC_W)) u_dac2 (
        .clk     (sys_clk),
        .rst_n   (rst_n),
        .cmd     (d2_cmd),
        .dac_out (dac2_out)
    );

    // =========================================================
    // heartbeat one-shots
    localparam logic [HB_CNT_W-1:0] HB_LOAD = HB_CNT_W'(HB_TICKS);
    logic [HB_CNT_W-1:0] hb_cnt_reg [AXES];
    logic [AXES-1:0]     hb_kick;

    assign hb_kick = {wr_d2_lo, wr_d1_lo};

    for (genvar g = 0; g < AXES; g++) begin : g_hb
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                hb_cnt_reg[g] <= '0;
            end else if (hb_kick[g]) begin
                hb_cnt_reg[g] <= HB_LOAD;
            end else if (hb_cnt_reg[g] != '0) begin
                hb_cnt_reg[g] <= hb_cnt_reg[g] - 1'b1;
            end
        end
    end

    logic [AXES-1:0] hb_now;
    assign hb_now = {hb_cnt_reg[1] != '0, hb_cnt_reg[0] != '0};

    // =========================================================
    // index latch and calibration capture
    logic [AXES-1:0] idx_flag_reg;
    logic [AXES-1:0] idx_d_reg;
    logic [AXES-1:0] capture_reg;
    logic [AXES-1:0] idx_sel;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_flag_reg <= '0;
            idx_d_reg    <= '0;
            capture_reg  <= '0;
        end else begin
            idx_d_reg <= idx_sel;
            if (!idx_en) begin
                idx_flag_reg <= '0;
            end else begin
                idx_flag_reg <= idx_flag_reg | idx_sel;
            end
            // every armed index edge captures, later ones too
            capture_reg <= idx_en ? (idx_sel & ~idx_d_reg) : '0;
        end
    end

    // =========================================================
    // encoder routing and board outputs
    logic [AXES-1:0] enc_a_next;
    logic [AXES-1:0] enc_b_next;
    logic [AXES-1:0] enc_i_next;
    logic            enc_real;

    assign enc_real   = port_b_reg[B_ENC_REAL];
    assign enc_a_next = enc_real ? enc_a_s : {AXES{port_a_reg[A_SYN_A]}};
    assign enc_b_next = enc_real ? enc_b_s : {AXES{port_a_reg[A_SYN_B]}};
    assign enc_i_next = enc_real ? enc_i_s : {AXES{port_a_reg[A_SYN_I]}};
    assign idx_sel    = enc_i_next;

    logic [AXES-1:0] enc_a_reg;
    logic [AXES-1:0] enc_b_reg;
    logic [AXES-1:0] enc_i_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            enc_a_reg <= '0;
            enc_b_reg <= '0;
            enc_i_reg <= '0;
        end else begin
            enc_a_reg <= enc_a_next;
            enc_b_reg <= enc_b_next;
            enc_i_reg <= enc_i_next;
        end
    end

    assign counter_mode    = port_a_reg[A_MODE_LSB +: A_MODE_W];
    assign diag_led        = {port_a_reg[A_LED2], port_a_reg[A_LED1]};
    assign dac_to_joints   = port_b_reg[B_DAC_JOINT];
    assign counter_enc_a   = enc_a_reg;
    assign counter_enc_b   = enc_b_reg;
    assign counter_enc_i   = enc_i_reg;
    assign counter_capture = capture_reg | {AXES{latch_reg}};
    assign board_latch     = latch_reg;
    assign heartbeat       = hb_now;

    // =========================================================
    // status port and read data
    logic [7:0] port_c_val;
    logic [7:0] rd_next;
    logic [7:0] rdata_reg;

    assign port_c_val = {3'h0,
                         !busy_s,
                         idx_flag_reg[1], hb_now[1],
                         idx_flag_reg[0],
                         hb_now[0]};

    assign rd_next = hit(io_addr, OFF_PORT_A)    ? port_a_reg    :
                     hit(io_addr, OFF_PORT_B)    ? port_b_reg    :
                     hit(io_addr, OFF_PORT_C)    ? port_c_val    :
                     hit(io_addr, OFF_PORT_CTRL) ? port_ctrl_reg : RDATA_UNMAP;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= RDATA_UNMAP;
        end else if (board_rd) begin
            rdata_reg <= rd_next;
        end
    end

    assign io_rdata = rdata_reg;
endmodule : servo_axis_control_port

// ==== testbench/servo_axis_control_port_asserts.sv ====
// Purpose: port-level checks for servo_axis_control_port
// Assumes: single clock, host strobes synchronous to sys_clk
// Notes:   heartbeat bound allows two cycles of slack
`timescale 1ns/1ps
module servo_axis_control_port_asserts
    import servo_port_pkg::*;
#(
    parameter longint HB_TICKS = servo_port_pkg::HB_CYCLES
) (
    // clock, reset and host bus
    input wire logic                                sys_clk,
    input wire logic                                nrst,
    input wire logic                                board_hit,
    input wire logic [4:0]                          io_addr,
    input wire logic                                io_wr,
    input wire logic                                io_rd,
    input wire logic [7:0]                          io_wdata,
    // outputs under watch
    input wire logic [servo_port_pkg::A_MODE_W-1:0] counter_mode,
    input wire logic [servo_port_pkg::AXES-1:0]     counter_enc_a,
    input wire logic [servo_port_pkg::AXES-1:0]     counter_enc_b,
    input wire logic [servo_port_pkg::AXES-1:0]     counter_enc_i,
    input wire logic [servo_port_pkg::AXES-1:0]     counter_capture,
    input wire logic                                board_latch,
    input wire logic                                dac_to_joints,
    input wire logic [servo_port_pkg::DAC_W-1:0]    dac1_out,
    input wire logic [servo_port_pkg::DAC_W-1:0]    dac2_out,
    input wire logic [servo_port_pkg::AXES-1:0]     diag_led,
    input wire logic [servo_port_pkg::AXES-1:0]     heartbeat
);
    // =========================================================
    // helper state
    logic [7:0] b_seen_reg;
    longint     hb_age_reg;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            b_seen_reg <= PORT_B_RST;
            hb_age_reg <= HB_TICKS + 8;
        end else begin
            if (board_hit && io_wr && io_addr == OFF_PORT_B) b_seen_reg <= io_wdata;
            if (board_hit && io_wr && io_addr == OFF_DAC1_LO) hb_age_reg <= 0;
            else if (hb_age_reg < HB_TICKS + 8) hb_age_reg <= hb_age_reg + 1;
        end
    end
    // =========================================================
    // properties
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_wr(logic [4:0] a);
        board_hit && io_wr && io_addr == a;
    endsequence
    sequence s_latch_acc;
        (io_wr || io_rd) && (io_addr == OFF_LATCH_ALL || (board_hit && io_addr == OFF_LATCH_BOARD));
    endsequence
    a_mode_lamp_write: assert property (s_wr(OFF_PORT_A) |=> counter_mode == $past(io_wdata[2:0]) && diag_led == $past(io_wdata[4:3])) else $error("mode or lamp mismatch");
    a_synthetic_route: assert property (s_wr(OFF_PORT_A) ##0 !b_seen_reg[B_ENC_REAL] |-> ##2 counter_enc_a == {AXES{$past(io_wdata[A_SYN_A], 2)}} && counter_enc_i == {AXES{$past(io_wdata[A_SYN_I], 2)}}) else $error("synthetic route mismatch");
    a_joint_path: assert property (s_wr(OFF_PORT_B) |=> dac_to_joints == $past(io_wdata[B_DAC_JOINT])) else $error("converter path mismatch");
    a_soft_latch: assert property (s_latch_acc |=> board_latch) else $error("no latch after access");
    a_latch_capture: assert property (board_latch |-> ##[0:1] counter_capture == 2'h3) else $error("latch without capture");
    a_hb_start: assert property (s_wr(OFF_DAC2_LO) |=> heartbeat[1]) else $error("heartbeat not started");
    a_hb_expire: assert property (hb_age_reg > HB_TICKS + 1 |-> !heartbeat[0]) else $error("heartbeat overran");
    a_dbl_hold: assert property (b_seen_reg[B_DBL_BUF] && !board_latch |=> $stable(dac1_out) && $stable(dac2_out)) else $error("buffered output moved");
    a_direct_load: assert property (s_wr(OFF_DAC1_HI) ##0 !b_seen_reg[B_DBL_BUF] |=> dac1_out[11:8] == $past(io_wdata[3:0])) else $error("direct load missed");
endmodule : servo_axis_control_port_asserts

bind servo_axis_control_port servo_axis_control_port_asserts #(.HB_TICKS(HB_TICKS))
    u_chk (.*);

// ==== testbench/servo_backplane_model.sv ====
// Purpose: backplane strobe, converter busy and joint encoder pins
// Assumes: requests from the bench on sys_clk
// Notes:   encoders hold fixed phases so routing is visible
`timescale 1ns/1ps
module servo_backplane_model
    import servo_port_pkg::*;
(
    // requests from the bench
    input  wire logic                            sys_clk,
    input  wire logic                            strobe_req,
    input  wire logic [servo_port_pkg::AXES-1:0] index_req,
    // latch from the block
    input  wire logic                            board_latch,
    // pins into the block
    output logic                                 sample_strobe_line,
    output logic                                 adc_busy,
    output logic [servo_port_pkg::AXES-1:0]      joint_enc_a,
    output logic [servo_port_pkg::AXES-1:0]      joint_enc_b,
    output logic [servo_port_pkg::AXES-1:0]      joint_enc_i
);
    int busy_left = 0;
    int strobe_left = 0;
    assign joint_enc_a = 2'h1;
    assign joint_enc_b = 2'h2;
    assign joint_enc_i = index_req;
    assign adc_busy = busy_left > 0;
    assign sample_strobe_line = strobe_left > 0;
    // conversion starts on every board latch
    always @(posedge sys_clk) begin
        if (board_latch === 1'b1) busy_left <= 6;
        else if (busy_left > 0) busy_left <= busy_left - 1;
        if (strobe_req) strobe_left <= 4;
        else if (strobe_left > 0) strobe_left <= strobe_left - 1;
    end
endmodule : servo_backplane_model

// ==== testbench/test_servo_axis_control_port.sv ====
// Purpose: self-checking bench for servo_axis_control_port
// Assumes: inputs change 1 ns after the rising edge
// Notes:   heartbeat shortened to 20 cycles
`timescale 1ns/1ps
module test_servo_axis_control_port;
    import servo_port_pkg::*;
    logic sys_clk, nrst, board_hit, io_wr, io_rd, strobe_req, sample_strobe_line, adc_busy;
    logic board_latch, dac_to_joints;
    logic [4:0] io_addr;
    logic [7:0] io_wdata, io_rdata, rdv;
    logic [1:0] index_req, joint_enc_a, joint_enc_b, joint_enc_i, cap_seen;
    logic [1:0] counter_enc_a, counter_enc_b, counter_enc_i, counter_capture, diag_led, heartbeat;
    logic [2:0] counter_mode;
    logic [11:0] dac1_out, dac2_out;
    int fails = 0;
    int checked = 0;
    int n_latch = 0;
    int n0, k;
    servo_axis_control_port #(.HB_TICKS(20), .DAC_ON_SW_LATCH(1'b1)) u_dut (.*);
    servo_backplane_model u_far (.*);
    // =========================================================
    // clock, monitor and shared tasks
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (board_latch === 1'b1) n_latch <= n_latch + 1;
        cap_seen <= cap_seen | counter_capture;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : chk
    // one host access, read data to rdv
    task automatic acc(input logic hit, input logic w, input logic [4:0] a, input logic [7:0] d);
        board_hit = hit;
        io_wr = w;
        io_rd = !w;
        io_addr = a;
        io_wdata = d;
        cyc(1);
        board_hit = 1'b0;
        io_wr = 1'b0;
        io_rd = 1'b0;
        cyc(1);
        rdv = io_rdata;
    endtask : acc
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        acc(1'b1, 1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [4:0] a);
        acc(1'b1, 1'b0, a, 8'h00);
    endtask : rd
    task automatic dac_load(input logic [4:0] lo, input logic [11:0] v);
        wr(lo, v[7:0]);
        wr(lo + 5'h01, {4'h0, v[11:8]});
    endtask : dac_load
    task automatic strobe();
        strobe_req = 1'b1;
        cyc(1);
        strobe_req = 1'b0;
    endtask : strobe
    task automatic index_pulse(input logic [1:0] which);
        index_req = which;
        cyc(4);
        index_req = 2'h0;
        cyc(6);
    endtask : index_pulse
    // =========================================================
    // scenarios
    task automatic t_reset_values();
        rd(OFF_PORT_A);
        chk("port A reset", rdv, PORT_A_RST);
        rd(OFF_PORT_B);
        chk("port B reset", rdv, PORT_B_RST);
        rd(5'h1f);
        chk("unmapped read", rdv, RDATA_UNMAP);
        rd(OFF_PORT_C);
        chk("status idle", rdv, 8'h10);
        $display("test reset values done");
    endtask : t_reset_values
    task automatic t_port_routing();
        wr(OFF_PORT_B, 8'h00);
        wr(OFF_PORT_A, 8'h6b);
        cyc(2);
        chk("mode", counter_mode, 3'h3);
        chk("lamps", diag_led, 2'h1);
        chk("syn abi", {counter_enc_a, counter_enc_b, counter_enc_i}, 6'h3c);
        wr(OFF_PORT_B, 8'he3);
        cyc(6);
        chk("real ab", {counter_enc_a, counter_enc_b}, 4'h6);
        chk("to joints", dac_to_joints, 1'b1);
        wr(OFF_PORT_C, 8'hff);
        rd(OFF_PORT_C);
        chk("port C read only", rdv, 8'h10);
        $display("test port routing done");
    endtask : t_port_routing
    task automatic t_dac_modes();
        wr(OFF_PORT_B, 8'h02);
        dac_load(OFF_DAC1_LO, 12'habc);
        chk("dac1 direct", dac1_out, 12'habc);
        wr(OFF_PORT_B, 8'h08);
        dac_load(OFF_DAC1_LO, 12'h456);
        n0 = n_latch;
        strobe();
        cyc(12);
        chk("strobe gated off", n_latch - n0, 16'h0);
        chk("dac1 held", dac1_out, 12'habc);
        wr(OFF_PORT_B, 8'h0c);
        dac_load(OFF_DAC2_LO, 12'h789);
        strobe();
        // pin, two sync flops, edge, latch register, then the counter
        cyc(6);
        chk("strobe latch", n_latch - n0, 16'h1);
        chk("both dacs", {dac1_out, dac2_out}, 24'h456789);
        dac_load(OFF_DAC1_LO, 12'h0f0);
        wr(OFF_LATCH_BOARD, 8'h00);
        cyc(3);
        chk("board latch", dac1_out, 12'h0f0);
        dac_load(OFF_DAC2_LO, 12'h3c3);
        cap_seen = 2'h0;
        acc(1'b0, 1'b0, OFF_LATCH_ALL, 8'h00);
        cyc(3);
        chk("latch all", dac2_out, 12'h3c3);
        chk("latch capture", cap_seen, 2'h3);
        wr(OFF_PORT_B, 8'h02);
        $display("test converter modes done");
    endtask : t_dac_modes
    task automatic t_heartbeat();
        cyc(30);
        rd(OFF_PORT_C);
        chk("hb expired", rdv, 8'h10);
        wr(OFF_DAC1_LO, 8'h11);
        wr(OFF_DAC2_LO, 8'h22);
        rd(OFF_PORT_C);
        chk("hb both", rdv, 8'h15);
        cyc(14);
        wr(OFF_DAC1_LO, 8'h33);
        cyc(12);
        rd(OFF_PORT_C);
        chk("hb retrigger", rdv, 8'h11);
        $display("test heartbeat done");
    endtask : t_heartbeat
    task automatic t_index_latch();
        wr(OFF_PORT_B, 8'h01);
        index_pulse(2'h1);
        rd(OFF_PORT_C);
        chk("idx disarmed", rdv & 8'h0a, 8'h00);
        wr(OFF_PORT_B, 8'h11);
        cap_seen = 2'h0;
        index_pulse(2'h1);
        rd(OFF_PORT_C);
        chk("idx1 set", rdv & 8'h0a, 8'h02);
        chk("idx1 capture", cap_seen, 2'h1);
        index_pulse(2'h2);
        rd(OFF_PORT_C);
        chk("idx2 set", rdv & 8'h0a, 8'h0a);
        wr(OFF_PORT_B, 8'h01);
        rd(OFF_PORT_C);
        chk("idx cleared", rdv & 8'h0a, 8'h00);
        $display("test index latch done");
    endtask : t_index_latch
    task automatic t_adc_status();
        wr(OFF_LATCH_BOARD, 8'h00);
        k = 0;
        do begin
            rd(OFF_PORT_C);
            k++;
        end while (rdv[4] !== 1'b0 && k < 10);
        chk("adc busy", rdv[4], 1'b0);
        // keep polling port C until bit 4 rises back to idle
        do begin
            rd(OFF_PORT_C);
            k++;
        end while (rdv[4] !== 1'b1 && k < 30);
        chk("adc done", rdv[4], 1'b1);
        $display("test converter status done");
    endtask : t_adc_status
    // =========================================================
    // verdict, watchdog and main sequence
    task automatic conclude();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    initial begin
        #20000;
        fails++;
        conclude();
    end
    initial begin
        {nrst, board_hit, io_wr, io_rd, strobe_req} = 5'h00;
        {io_addr, io_wdata, index_req, cap_seen} = 17'h00000;
        cyc(5);
        nrst = 1'b1;
        cyc(4);
        t_reset_values();
        t_port_routing();
        t_dac_modes();
        t_heartbeat();
        t_index_latch();
        t_adc_status();
        conclude();
    end
endmodule : test_servo_axis_control_port
